// ---- design/rt_mode_status.sv ----
// Purpose: terminal mode-code handling, status word and address gating
// Assumes: decoded commands arrive from a word decoder on aclk
// Notes: registers reached over AXI4-Lite; ce low freezes all state
//
// Overview of operation
// RULE1: any wired address 0 to 30 is accepted as own address
// RULE2: address comes only from external wiring pins
// RULE3: wiring is sampled and judged after power-up reset
// RULE4: two independent captures and verdicts must agree to trust address
// RULE5: with an invalid address the terminal never responds
// RULE6: subaddress 00000 and 11111 both mean a mode command, alike
// RULE7: the controller may use either mode subaddress value
// RULE8: decode transmit status, shutdown, override shutdown and reset codes
// RULE9: the controller can issue all codes, never dynamic bus control
// RULE10: reset code sends status first, then internal reset starts
// RULE11: while resetting, reply normally with busy set; data stays valid
// RULE12: reset completes within 5.0 ms after the status word
// RULE13: self test code sends status, then tests; new commands abort
// RULE14: during self test, reply normally with busy set
// RULE15: self test completes with results within 100.0 ms
// RULE16: status word holds valid contents from reset onward
// RULE17: message error implemented; instrumentation and reserved bits zero
// RULE18: broadcast received bit implemented
// RULE19: subsystem flag bit implemented
// RULE20: busy set only by reset or self test commands
// RULE21: terminal flag bit implemented for self test fault
// RULE22: internal counters on local clock enforce the time limits
//
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
module rt_mode_status
	import rt_ctl_pkg::*;
#(
	parameter int RESET_CYC = RESET_LIMIT_US * 1000 / CLK_PERIOD_NS,
	parameter int SELFTEST_CYC = SELFTEST_LIMIT_US * 1000 / CLK_PERIOD_NS
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [4:0] addr_pin,
	input wire logic addr_par_pin,
	input wire logic cmd_valid,
	input wire logic [4:0] cmd_rt_addr,
	input wire logic cmd_tx,
	input wire logic [4:0] cmd_subaddr,
	input wire logic [4:0] cmd_count,
	input wire logic cmd_bus,
	input wire logic cmd_msg_err,
	input wire logic status_sent,
	input wire logic subsys_fail,
	output logic resp_req,
	output logic [15:0] status_word,
	output logic [1:0] tx_shutdown,
	output logic rt_busy,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ****************************************
	// declarations
	// ****************************************
	rt_state_e state_r, state_nxt;
	logic addr_ok, mismatch, tmr_run, tmr_done, tmr_start, tmr_abort;
	logic [4:0] own_addr;
	logic own_cmd, bc_cmd, mode_cmd, any_cmd;
	logic me_r, me_nxt, bcr_r, bcr_nxt, tf_r, tf_nxt;
	logic [1:0] shut_r, shut_nxt;
	logic [15:0] sw_r, sw_nxt;
	logic sr_r, sr_nxt, reval_r, reval_nxt, por_r;
	logic [TMR_W-1:0] tmr_limit;
	logic [7:0] awaddr_r, awaddr_nxt;
	logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
	logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic do_write;

	// mode command when subaddress is either marker value
	function automatic logic is_mode(input logic [4:0] sa);
		is_mode = (sa == SA_MODE_LO) || (sa == SA_MODE_HI); // see RULE6
	endfunction

	// ****************************************
	// address validation and limit timer
	// ****************************************
	rt_addr_check u_addr (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.revalidate(por_r || reval_r),
		.addr_pin(addr_pin),
		.addr_par_pin(addr_par_pin),
		.addr_ok(addr_ok),
		.own_addr(own_addr),
		.mismatch(mismatch)
	);

	assign tmr_limit = (state_r == ST_RST_RESP) ? TMR_W'(RESET_CYC) :
		TMR_W'(SELFTEST_CYC);

	rt_limit_timer u_tmr (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.start(tmr_start),
		.abort(tmr_abort),
		.limit(tmr_limit),
		.running(tmr_run),
		.done(tmr_done)
	);

	// ****************************************
	// command decode
	// ****************************************
	assign own_cmd = ce && cmd_valid && addr_ok && (cmd_rt_addr == own_addr); // see RULE1
	assign bc_cmd = ce && cmd_valid && addr_ok && (cmd_rt_addr == BCAST_ADDR);
	assign any_cmd = own_cmd || bc_cmd;
	assign mode_cmd = is_mode(cmd_subaddr);
	// no reply unless address valid, not broadcast, no message error
	assign resp_req = own_cmd && !cmd_msg_err; // see RULE5
	assign tmr_start = ce && (((state_r == ST_RST_RESP) ||
		(state_r == ST_TST_RESP)) && status_sent);
	assign tmr_abort = ce && (state_r == ST_SELFTEST) && any_cmd; // see RULE13

	// ****************************************
	// mode state machine
	// ****************************************
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (any_cmd && mode_cmd && !cmd_msg_err && cmd_tx) begin
					if (cmd_count == MC_RESET) begin
						state_nxt = ST_RST_RESP; // see RULE10
					end else if (cmd_count == MC_SELF_TEST) begin
						state_nxt = ST_TST_RESP; // see RULE13
					end
				end
			end
			ST_RST_RESP: begin
				if (status_sent) begin
					state_nxt = ST_RESETTING; // see RULE10
				end
			end
			ST_RESETTING: begin
				if (tmr_done) begin
					state_nxt = ST_IDLE; // see RULE12
				end
			end
			ST_TST_RESP: begin
				if (status_sent) begin
					state_nxt = ST_SELFTEST;
				end
			end
			ST_SELFTEST: begin
				if (tmr_done || tmr_abort) begin
					state_nxt = ST_IDLE; // see RULE15
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// ****************************************
	// status flags and shutdown
	// ****************************************
	always_comb begin
		me_nxt = me_r;
		bcr_nxt = bcr_r;
		tf_nxt = tf_r;
		shut_nxt = shut_r;
		if (state_r == ST_RESETTING && tmr_done) begin
			me_nxt = 1'b0; // reset function clears terminal state
			bcr_nxt = 1'b0;
			tf_nxt = 1'b0;
			shut_nxt = 2'h0;
		end
		// a command other than transmit status landing with the reset clear wins over it
		if (any_cmd && !(mode_cmd && cmd_count == MC_TX_STATUS)) begin
			me_nxt = cmd_msg_err; // see RULE17
			bcr_nxt = bc_cmd; // see RULE18
		end
		if (any_cmd && mode_cmd && !cmd_msg_err && cmd_tx) begin
			if (cmd_count == MC_TX_SHUT) begin
				shut_nxt[~cmd_bus] = 1'b1; // see RULE8
			end else if (cmd_count == MC_OVR_SHUT) begin
				shut_nxt[~cmd_bus] = 1'b0; // see RULE8
			end
		end
		if (state_r == ST_TST_RESP && status_sent) begin
			tf_nxt = 1'b0;
		end else if (state_r == ST_SELFTEST && mismatch) begin
			tf_nxt = 1'b1; // see RULE21
		end
	end

	// busy only from reset or self test in progress
	assign rt_busy = (state_r == ST_RESETTING) || (state_r == ST_SELFTEST); // see RULE20

	// assemble the word; fixed-zero bits never written
	always_comb begin
		sw_nxt = 16'h0000; // see RULE17
		sw_nxt[SW_ADDR_LSB +: 5] = own_addr;
		sw_nxt[SW_ME] = me_nxt;
		sw_nxt[SW_SR] = sr_r;
		sw_nxt[SW_BCR] = bcr_nxt;
		sw_nxt[SW_BUSY] = rt_busy; // see RULE11 RULE14
		sw_nxt[SW_SF] = subsys_fail; // see RULE19
		sw_nxt[SW_TF] = tf_nxt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= ST_IDLE;
			me_r <= 1'b0;
			bcr_r <= 1'b0;
			tf_r <= 1'b0;
			shut_r <= 2'h0;
			sw_r <= 16'h0000; // see RULE16
			por_r <= 1'b1;
		end else if (ce) begin
			state_r <= state_nxt;
			me_r <= me_nxt;
			bcr_r <= bcr_nxt;
			tf_r <= tf_nxt;
			shut_r <= shut_nxt;
			sw_r <= sw_nxt;
			por_r <= 1'b0;
		end
	end

	assign status_word = sw_r;
	assign tx_shutdown = shut_r;

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	assign do_write = aw_got_r && w_got_r && !bvalid_r;

	always_comb begin
		awaddr_nxt = awaddr_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		aw_got_nxt = aw_got_r;
		w_got_nxt = w_got_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		sr_nxt = sr_r;
		reval_nxt = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			awaddr_nxt = s_axi_awaddr;
			aw_got_nxt = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wdata_nxt = s_axi_wdata;
			wstrb_nxt = s_axi_wstrb;
			w_got_nxt = 1'b1;
		end
		if (do_write) begin
			aw_got_nxt = 1'b0;
			w_got_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = RESP_SLVERR;
			if (awaddr_r == REG_CTRL) begin
				bresp_nxt = RESP_OKAY;
				if (wstrb_r[0]) begin
					sr_nxt = wdata_r[CTRL_SR];
					reval_nxt = wdata_r[CTRL_REVAL];
				end
			end else if (awaddr_r == REG_STAT || awaddr_r == REG_SWORD) begin
				bresp_nxt = RESP_OKAY; // read-only, write ignored
			end
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
	end

	// read mux, unmapped answers slave error with zero data
	always_comb begin
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		rvalid_nxt = rvalid_r;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = RESP_OKAY;
			rdata_nxt = 32'h0000_0000;
			case (s_axi_araddr)
				REG_CTRL: rdata_nxt[CTRL_SR] = sr_r;
				REG_STAT: rdata_nxt[11:0] = {shut_r, tf_r,
					state_r == ST_SELFTEST, state_r == ST_RESETTING,
					rt_busy, own_addr, addr_ok};
				REG_SWORD: rdata_nxt[15:0] = sw_r;
				default: rresp_nxt = RESP_SLVERR;
			endcase
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= 2'h0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= 2'h0;
			rvalid_r <= 1'b0;
			sr_r <= 1'b0;
			reval_r <= 1'b0;
		end else if (ce) begin
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
			rvalid_r <= rvalid_nxt;
			sr_r <= sr_nxt;
			reval_r <= reval_nxt;
		end
	end

	assign s_axi_awready = ce && !aw_got_r;
	assign s_axi_wready = ce && !w_got_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = ce && !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// ****************************************
	// assertions
	// ****************************************
	logic [TMR_W-1:0] busy_cnt_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_cnt_r <= '0;
		end else if (ce) begin
			busy_cnt_r <= rt_busy ? busy_cnt_r + TMR_W'(1) : '0;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	silent_bad_addr_a: assert property ( // see RULE5
		!addr_ok |-> !resp_req) else $error("reply with invalid address");
	addr_range_a: assert property ( // see RULE1
		addr_ok |-> own_addr != BCAST_ADDR) else $error("address 31 trusted");
	mode_reset_a: assert property ( // see RULE6
		state_r == ST_IDLE && own_cmd && !cmd_msg_err && cmd_tx &&
		is_mode(cmd_subaddr) && cmd_count == MC_RESET
		|=> state_r == ST_RST_RESP) else $error("reset code not taken");
	status_first_a: assert property ( // see RULE10
		state_r == ST_RST_RESP |-> !tmr_run) else $error("reset before status");
	reset_limit_a: assert property ( // see RULE12
		state_r == ST_RESETTING |-> busy_cnt_r <= TMR_W'(RESET_CYC))
		else $error("reset overran limit");
	selftest_limit_a: assert property ( // see RULE15
		state_r == ST_SELFTEST |-> busy_cnt_r <= TMR_W'(SELFTEST_CYC))
		else $error("self test overran limit");
	zero_bits_a: assert property ( // see RULE17
		sw_r[SW_INSTR] == 1'b0 && sw_r[SW_RSV_LSB +: 3] == 3'h0 &&
		sw_r[SW_DBCA] == 1'b0) else $error("fixed status bit set");
	busy_cause_a: assert property ( // see RULE20
		ce && $rose(sw_r[SW_BUSY]) |-> $past(state_r) == ST_RESETTING ||
		$past(state_r) == ST_SELFTEST) else $error("busy without cause");
	bcast_bit_a: assert property ( // see RULE18
		bc_cmd && !(is_mode(cmd_subaddr) && cmd_count == MC_TX_STATUS)
		|=> sw_r[SW_BCR]) else $error("broadcast bit not set");
	abort_test_a: assert property ( // see RULE13
		state_r == ST_SELFTEST && tmr_abort |=> state_r == ST_IDLE)
		else $error("self test not aborted");

	reset_seen_c: cover property (state_r == ST_RESETTING ##1 state_r == ST_IDLE);
	selftest_seen_c: cover property (state_r == ST_SELFTEST && tmr_done);
	shutdown_seen_c: cover property (shut_r != 2'h0);
	addr_ok_seen_c: cover property ($rose(addr_ok));
endmodule

// ---- design/rt_ctl_pkg.sv ----
// Purpose: shared constants of the terminal mode and status logic
// Assumes: 25 MHz local clock, AXI4-Lite register access
// Notes: cycle counts derived in the top module from these times
package rt_ctl_pkg;
	// ****************************************
	// clock and time limits
	// ****************************************
	localparam int CLK_PERIOD_NS = 40;
	localparam int RESET_LIMIT_US = 5000; // 5.0 ms
	localparam int SELFTEST_LIMIT_US = 100000; // 100.0 ms
	localparam int TMR_W = 22;
	localparam int VAL_SETTLE = 4; // cycles between address samples

	// ****************************************
	// command word fields
	// ****************************************
	localparam logic [4:0] SA_MODE_LO = 5'h00;
	localparam logic [4:0] SA_MODE_HI = 5'h1F;
	localparam logic [4:0] BCAST_ADDR = 5'h1F;
	localparam logic [4:0] MC_TX_STATUS = 5'h02;
	localparam logic [4:0] MC_SELF_TEST = 5'h03;
	localparam logic [4:0] MC_TX_SHUT = 5'h04;
	localparam logic [4:0] MC_OVR_SHUT = 5'h05;
	localparam logic [4:0] MC_RESET = 5'h08;

	// ****************************************
	// status word layout (16 content bits)
	// ****************************************
	localparam int SW_ADDR_LSB = 11;
	localparam int SW_ME = 10;
	localparam int SW_INSTR = 9;
	localparam int SW_SR = 8;
	localparam int SW_RSV_LSB = 5;
	localparam int SW_BCR = 4;
	localparam int SW_BUSY = 3;
	localparam int SW_SF = 2;
	localparam int SW_DBCA = 1;
	localparam int SW_TF = 0;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_SWORD = 8'h08;
	localparam int CTRL_SR = 0;
	localparam int CTRL_REVAL = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RST_RESP = 5'h02,
		ST_RESETTING = 5'h04,
		ST_TST_RESP = 5'h08,
		ST_SELFTEST = 5'h10
	} rt_state_e;
endpackage

// ---- design/rt_addr_check.sv ----
// Purpose: samples and validates the wired terminal address
// Assumes: address and parity pins are static wiring, asynchronous
// Notes: two independent captures must agree before address is trusted
module rt_addr_check
	import rt_ctl_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic revalidate,
	input wire logic [4:0] addr_pin,
	input wire logic addr_par_pin,
	output logic addr_ok,
	output logic [4:0] own_addr,
	output logic mismatch
);
	logic [5:0] s1_r, s2_r;
	logic [5:0] cap_a_r, cap_a_nxt, cap_b_r, cap_b_nxt;
	logic [3:0] step_r, step_nxt;
	logic ok_a_r, ok_a_nxt, ok_b_r, ok_b_nxt;

	// odd parity over address and parity pin, broadcast code refused
	function automatic logic addr_good(input logic [5:0] v);
		addr_good = (^v) && (v[4:0] != BCAST_ADDR);
	endfunction

	// two-flop synchroniser on the wiring pins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_r <= 6'h00;
			s2_r <= 6'h00;
		end else if (ce) begin
			s1_r <= {addr_par_pin, addr_pin};
			s2_r <= s1_r;
		end
	end

	// capture twice, judge each capture on its own path
	always_comb begin
		cap_a_nxt = cap_a_r;
		cap_b_nxt = cap_b_r;
		ok_a_nxt = ok_a_r;
		ok_b_nxt = ok_b_r;
		step_nxt = step_r;
		if (revalidate) begin
			step_nxt = 4'h0; // see RULE3
			ok_a_nxt = 1'b0;
			ok_b_nxt = 1'b0;
		end else if (step_r == 4'(VAL_SETTLE)) begin
			cap_a_nxt = s2_r; // see RULE3
			step_nxt = step_r + 4'h1;
		end else if (step_r == 4'(2 * VAL_SETTLE)) begin
			cap_b_nxt = s2_r;
			step_nxt = step_r + 4'h1;
		end else if (step_r == 4'(2 * VAL_SETTLE + 1)) begin
			ok_a_nxt = addr_good(cap_a_r) && (cap_a_r == cap_b_r); // see RULE4
			ok_b_nxt = addr_good(cap_b_r) && (cap_b_r == cap_a_r); // see RULE4
			step_nxt = step_r + 4'h1;
		end else if (step_r < 4'(2 * VAL_SETTLE + 1)) begin
			step_nxt = step_r + 4'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cap_a_r <= 6'h00;
			cap_b_r <= 6'h00;
			ok_a_r <= 1'b0;
			ok_b_r <= 1'b0;
			step_r <= 4'h0;
		end else if (ce) begin
			cap_a_r <= cap_a_nxt;
			cap_b_r <= cap_b_nxt;
			ok_a_r <= ok_a_nxt;
			ok_b_r <= ok_b_nxt;
			step_r <= step_nxt;
		end
	end

	// both verdicts and both stored copies must still agree
	assign mismatch = (cap_a_r != cap_b_r);
	assign addr_ok = ok_a_r && ok_b_r && !mismatch; // see RULE4
	assign own_addr = cap_a_r[4:0]; // see RULE2
endmodule

// ---- design/rt_limit_timer.sv ----
// Purpose: down counter enforcing reset and self-test time limits
// Assumes: limit held stable while running
// Notes: done pulses one cycle when the count expires
module rt_limit_timer
	import rt_ctl_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic start,
	input wire logic abort,
	input wire logic [TMR_W-1:0] limit,
	output logic running,
	output logic done
);
	logic [TMR_W-1:0] cnt_r, cnt_nxt;
	logic run_r, run_nxt;

	// load on start, count to one, then stop
	always_comb begin
		cnt_nxt = cnt_r;
		run_nxt = run_r;
		if (abort) begin
			run_nxt = 1'b0;
		end else if (start) begin
			cnt_nxt = limit;
			run_nxt = 1'b1;
		end else if (run_r) begin
			cnt_nxt = cnt_r - TMR_W'(1);
			if (cnt_r <= TMR_W'(1)) begin
				run_nxt = 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= '0;
			run_r <= 1'b0;
		end else if (ce) begin
			cnt_r <= cnt_nxt;
			run_r <= run_nxt;
		end
	end

	assign running = run_r;
	assign done = run_r && (cnt_r <= TMR_W'(1)) && !abort && ce; // see RULE22
endmodule

// ---- bench/bc_model.sv ----
// Purpose: bus controller side, issues decoded commands to the terminal
// Assumes: one command in flight, status end marked after a chosen gap
// Notes: idle command fields carry the inverse of the last command
module bc_model (
	input wire logic aclk,
	input wire logic resp_req,
	input wire logic [15:0] status_word,
	output logic cmd_valid,
	output logic [4:0] cmd_rt_addr,
	output logic cmd_tx,
	output logic [4:0] cmd_subaddr,
	output logic [4:0] cmd_count,
	output logic cmd_bus,
	output logic cmd_msg_err,
	output logic status_sent
);
	timeunit 1ns;
	timeprecision 1ns;
	// quiet port at time zero
	initial begin
		cmd_valid = 1'b0;
		status_sent = 1'b0;
		{cmd_rt_addr, cmd_tx, cmd_subaddr, cmd_count, cmd_bus} = '0;
		cmd_msg_err = 1'b0;
	end
	// one command; either mode subaddress, never dynamic bus control
	task automatic send(input logic [4:0] ra, input logic [4:0] sa,
		input logic [4:0] mc, input logic bus, input logic me,
		input int gap, output logic got, output logic [15:0] sw);
		@(posedge aclk);
		cmd_valid <= 1'b1;
		{cmd_rt_addr, cmd_tx, cmd_subaddr} <= {ra, 1'b1, sa};
		{cmd_count, cmd_bus, cmd_msg_err} <= {mc, bus, me};
		@(negedge aclk);
		got = resp_req;
		@(posedge aclk);
		cmd_valid <= 1'b0;
		{cmd_rt_addr, cmd_tx, cmd_subaddr} <= ~{ra, 1'b1, sa};
		{cmd_count, cmd_bus, cmd_msg_err} <= ~{mc, bus, me};
		@(negedge aclk);
		sw = status_word;
		if (got) begin
			repeat (gap) @(posedge aclk);
			status_sent <= 1'b1;
			@(posedge aclk);
			status_sent <= 1'b0;
		end
	endtask
endmodule

// ---- bench/rt_mode_status_test.sv ----
// Purpose: self-checking bench of the terminal mode and status logic
// Assumes: bc_model drives the decoded command port
// Notes: short time limits set through parameters
module rt_mode_status_test
	import rt_ctl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int RC = 20;
	localparam int SC = 40;
	logic aclk = 0, aresetn = 0, ce = 1, subsys_fail = 0;
	logic addr_par_pin = 1;
	logic [4:0] addr_pin = 0, own = 0, a, sa;
	logic cmd_valid, cmd_tx, cmd_bus, cmd_msg_err, status_sent;
	logic [4:0] cmd_rt_addr, cmd_subaddr, cmd_count;
	logic resp_req, rt_busy, awready, wready, bvalid, arready, rvalid;
	logic [15:0] status_word, sw;
	logic [1:0] tx_shutdown, bresp, rresp, rr;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, rd;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic me = 0, bcr = 0, sr = 0, ok = 1, got;
	int fails = 0, comparisons = 0, n;
	int lim [3] = '{RC + 2, SC + 2, 3};

	// ****************************************
	// design, far side and clock
	// ****************************************
	rt_mode_status #(.RESET_CYC(RC), .SELFTEST_CYC(SC)) u_dut (
		.aclk(aclk), .aresetn(aresetn), .ce(ce), .addr_pin(addr_pin),
		.addr_par_pin(addr_par_pin), .cmd_valid(cmd_valid),
		.cmd_rt_addr(cmd_rt_addr), .cmd_tx(cmd_tx),
		.cmd_subaddr(cmd_subaddr), .cmd_count(cmd_count),
		.cmd_bus(cmd_bus), .cmd_msg_err(cmd_msg_err),
		.status_sent(status_sent), .subsys_fail(subsys_fail),
		.resp_req(resp_req), .status_word(status_word),
		.tx_shutdown(tx_shutdown), .rt_busy(rt_busy),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
	);
	bc_model u_bc (
		.aclk(aclk), .resp_req(resp_req), .status_word(status_word),
		.cmd_valid(cmd_valid), .cmd_rt_addr(cmd_rt_addr), .cmd_tx(cmd_tx),
		.cmd_subaddr(cmd_subaddr), .cmd_count(cmd_count),
		.cmd_bus(cmd_bus), .cmd_msg_err(cmd_msg_err),
		.status_sent(status_sent)
	);
	// free-running local clock
	always #20 aclk = ~aclk;

	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// expected status word from the bench model
	function automatic logic [15:0] exp_sw(input logic busy);
		return {own, me, 1'b0, sr, 3'h0, bcr, busy, subsys_fail, 2'h0};
	endfunction
	task automatic axw(input logic [7:0] ad, input logic [31:0] d);
		logic aw, w;
		aw = 0;
		w = 0;
		@(posedge aclk);
		awaddr <= ad;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge aclk);
			aw = aw | awready;
			w = w | wready;
			awvalid <= !aw;
			wvalid <= !w;
		end
		while (bvalid !== 1'b1) @(posedge aclk);
		rr = bresp;
		bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] ad);
		@(posedge aclk);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rd = rdata;
		rr = rresp;
		rready <= 1'b0;
	endtask
	// command through the far side, model follows
	task automatic cmd(input logic [4:0] ra, input logic [4:0] mc,
		input logic [4:0] s, input logic m, input logic bus, input int gap);
		u_bc.send(ra, s, mc, bus, m, gap, got, sw);
		if (ok && mc != MC_TX_STATUS && (ra == own || ra == 5'h1F)) begin
			me = m;
			bcr = (ra == 5'h1F);
		end
	endtask
	task automatic close_out;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		void'($urandom(54901));
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		// address 0, 30, 31, bad parity, then a random valid one
		for (int i = 0; i < 5; i++) begin
			a = (i == 0) ? 5'h00 : (i == 1) ? 5'h1E : (i == 2) ? 5'h1F :
				5'($urandom % 31);
			ok = (i != 2 && i != 3);
			@(posedge aclk);
			addr_pin <= a;
			addr_par_pin <= ~^a ^ (i == 3);
			if (ok)
				own = a;
			axw(REG_CTRL, {30'h0, 1'b1, sr});
			repeat (20) @(posedge aclk);
			axr(REG_STAT);
			chk({rd[0], rr}, {ok, RESP_OKAY});
			chk(rd[5:1] & {5{ok}}, a & {5{ok}});
			cmd((i == 2) ? 5'h1E : a, MC_TX_STATUS, SA_MODE_LO, 0, 0, 1);
			chk(got, ok);
			if (ok)
				chk(sw, exp_sw(0));
		end
		sr = 1;
		axw(REG_CTRL, 32'h1);
		chk(rr, RESP_OKAY);
		for (int s = 0; s < 2; s++) begin
			sa = s ? SA_MODE_HI : SA_MODE_LO;
			@(posedge aclk);
			subsys_fail <= 1'($urandom);
			cmd(own, MC_TX_STATUS, sa, 0, 0, 1);
			chk(got, 1);
			chk(sw, exp_sw(0));
			cmd(own, MC_TX_SHUT, sa, 0, s[0], 1);
			chk(tx_shutdown, s ? 2'b01 : 2'b10);
			cmd(own, MC_OVR_SHUT, sa, 0, s[0], 1);
			chk(tx_shutdown, 2'b00);
		end
		cmd(own, MC_OVR_SHUT, SA_MODE_LO, 1, 0, 1);
		chk(got, 0);
		cmd(own, MC_TX_STATUS, SA_MODE_HI, 0, 0, 1);
		chk(sw, exp_sw(0));
		cmd(5'h1F, MC_OVR_SHUT, SA_MODE_LO, 0, 0, 1);
		chk(got, 0);
		cmd(own, MC_TX_STATUS, SA_MODE_LO, 0, 0, 1);
		chk(sw, exp_sw(0));
		axw(REG_SWORD, 32'h0000_FFFF);
		chk(rr, RESP_OKAY);
		axw(8'h0C, 32'h3);
		chk(rr, RESP_SLVERR);
		axr(REG_SWORD);
		chk(rd, {16'h0, exp_sw(0)});
		axr(8'h0C);
		chk({rd[1:0], rr}, {2'h0, RESP_SLVERR});
		// clock enable low freezes the word and holds the bus off
		@(posedge aclk);
		ce <= 1'b0;
		repeat (5) @(posedge aclk);
		@(negedge aclk);
		chk({awready, arready, status_word}, {2'b00, exp_sw(0)});
		@(posedge aclk);
		ce <= 1'b1;
		// reset, full self test, aborted self test
		for (int k = 0; k < 3; k++) begin
			cmd(own, MC_TX_SHUT, SA_MODE_LO, 0, 0, 1);
			cmd(own, k ? MC_SELF_TEST : MC_RESET, SA_MODE_HI, 0, 0, 5);
			chk(sw, exp_sw(0));
			@(posedge aclk);
			@(negedge aclk);
			chk(rt_busy, 1);
			if (k != 1)
				cmd(own, MC_TX_STATUS, SA_MODE_LO, 0, 0, 1);
			if (k == 0)
				chk(sw, exp_sw(1));
			n = 0;
			while (rt_busy === 1'b1 && n < 3 * SC) begin
				@(negedge aclk);
				n++;
			end
			chk(n <= lim[k], 1);
			chk(tx_shutdown, k ? 2'b10 : 2'b00);
			cmd(own, MC_TX_STATUS, SA_MODE_LO, 0, 0, 1);
			chk(sw, exp_sw(0));
		end
		close_out;
	end
	// watchdog against a hung handshake
	initial begin
		repeat (6000) @(posedge aclk);
		fails++;
		close_out;
	end
endmodule
